// ---- verilog/ks_map.svh ----
// constants for the key stream to burst field bit mapper
// Summary of operation
// - single-subfield protected: A-field handled like unprotected
// - protected B bit i meets segment bit i+offset, as unprotected
// - encrypted B count from slot and configuration
// - unprotected long slot counts; offsets 80/120 for 4a/4b
// - single-subfield protected uses tabulated reduced counts
// - segment length is leading part plus unprotected B count
// - ciphered A-field XORs leading bits, else discards
// - unprotected B bit i meets bit i+offset
`ifndef KS_MAP_SVH
`define KS_MAP_SVH

// ============================================================
// leading part of each segment, per configuration family
`define KSM_LEAD_BASE 40
`define KSM_LEAD_4A 80
`define KSM_LEAD_4B 120

// ============================================================
// unprotected B-field bits at the lowest modulation level
`define KSM_B_DOUBLE 800
`define KSM_B_FULL 320
`define KSM_B_LONG640 640
`define KSM_B_LONG672 672

// ============================================================
// single-subfield protected reductions and printed exception
`define KSM_SP_TRIM 32
`define KSM_SP_TRIM_FULL_LOW 16
`define KSM_SP_LONG672_CFG5 2556

// ============================================================
// counter width needed for the longest segment (40 + 4800)
`define KSM_CNT_MIN_W 13

`endif

// ---- verilog/ks_pkg.sv ----
// types for the key stream to burst field bit mapper
package ks_pkg;

    // ============================================================
    // burst description
    typedef enum logic [1:0] {
        SLOT_DOUBLE,
        SLOT_FULL,
        SLOT_LONG640,
        SLOT_LONG672
    } slot_t;

    typedef enum logic [2:0] {
        CFG_1A,
        CFG_1B,
        CFG_2,
        CFG_3,
        CFG_4A,
        CFG_4B,
        CFG_5,
        CFG_6
    } mod_cfg_t;

    typedef enum logic [1:0] {
        FMT_UNPROT,
        FMT_ENC_PROT,
        FMT_SINGLE_PROT
    } bfmt_t;

    typedef struct packed {
        slot_t slot;
        mod_cfg_t cfg;
        bfmt_t fmt;
        logic a_ciphered;
    } burst_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_A,
        ST_B,
        ST_TAIL
    } map_state_t;

endpackage : ks_pkg

// ---- verilog/keystream_bfield_xor_mapper.sv ----
// bit-serial mapper of key stream segment bits onto A- and B-field bits
`timescale 1ns/1ps
`default_nettype none
`include "ks_map.svh"

module keystream_bfield_xor_mapper #(
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start_valid,
    output logic start_ready,
    input wire ks_pkg::burst_cfg_t start_cfg,
    input wire logic key_valid,
    input wire logic key_bit,
    output logic key_ready,
    input wire logic pay_valid,
    input wire logic pay_bit,
    output logic pay_ready,
    output logic out_valid,
    output logic out_bit,
    output logic out_is_b,
    input wire logic out_ready,
    output logic seg_done
);

    // ============================================================
    // elaboration check: a narrow counter would wrap inside a segment
    if (CNT_W < `KSM_CNT_MIN_W)
    begin : g_cnt_w_check
        $error("CNT_W too narrow for the longest segment");
    end

    // ============================================================
    // mapping tables
    function automatic logic [CNT_W-1:0] mult_of(input ks_pkg::mod_cfg_t c);
        unique case (c)
            ks_pkg::CFG_1A, ks_pkg::CFG_1B: mult_of = CNT_W'(1);
            ks_pkg::CFG_2, ks_pkg::CFG_4A: mult_of = CNT_W'(2);
            ks_pkg::CFG_3, ks_pkg::CFG_4B: mult_of = CNT_W'(3);
            ks_pkg::CFG_5: mult_of = CNT_W'(4);
            ks_pkg::CFG_6: mult_of = CNT_W'(6);
        endcase
    endfunction : mult_of

    function automatic logic [CNT_W-1:0] lead_of(input ks_pkg::mod_cfg_t c);
        unique case (c)
            ks_pkg::CFG_4A: lead_of = CNT_W'(`KSM_LEAD_4A);
            ks_pkg::CFG_4B: lead_of = CNT_W'(`KSM_LEAD_4B);
            default: lead_of = CNT_W'(`KSM_LEAD_BASE);
        endcase
    endfunction : lead_of

    // unprotected and encoded-protected share one count
    function automatic logic [CNT_W-1:0] unprot_of(input ks_pkg::burst_cfg_t b);
        logic [CNT_W-1:0] base;
        base = CNT_W'(`KSM_B_DOUBLE);
        unique case (b.slot)
            ks_pkg::SLOT_DOUBLE: base = CNT_W'(`KSM_B_DOUBLE);
            ks_pkg::SLOT_FULL: base = CNT_W'(`KSM_B_FULL);
            ks_pkg::SLOT_LONG640: base = CNT_W'(`KSM_B_LONG640);
            ks_pkg::SLOT_LONG672: base = CNT_W'(`KSM_B_LONG672);
        endcase
        unprot_of = CNT_W'(base * mult_of(b.cfg));
    endfunction : unprot_of

    function automatic logic [CNT_W-1:0] bcount_of(input ks_pkg::burst_cfg_t b);
        logic [CNT_W-1:0] full;
        logic low_cfg;
        full = unprot_of(b);
        low_cfg = (b.cfg == ks_pkg::CFG_1A) || (b.cfg == ks_pkg::CFG_1B);
        if (b.fmt != ks_pkg::FMT_SINGLE_PROT)
            bcount_of = full;
        else if (b.slot == ks_pkg::SLOT_LONG672 && b.cfg == ks_pkg::CFG_5)
            bcount_of = CNT_W'(`KSM_SP_LONG672_CFG5);
        else if (b.slot == ks_pkg::SLOT_FULL && low_cfg)
            bcount_of = full - CNT_W'(`KSM_SP_TRIM_FULL_LOW);
        else
            bcount_of = full - CNT_W'(`KSM_SP_TRIM);
    endfunction : bcount_of

    // ============================================================
    // state
    ks_pkg::map_state_t state_q, state_d;
    ks_pkg::burst_cfg_t cfg_q, cfg_d;
    logic [CNT_W-1:0] kidx_q, kidx_d;
    logic [CNT_W-1:0] bidx_q, bidx_d;
    logic [CNT_W-1:0] lead_q, lead_d;
    logic [CNT_W-1:0] bcnt_q, bcnt_d;
    logic [CNT_W-1:0] segmax_q, segmax_d;
    logic out_valid_q, out_valid_d;
    logic out_bit_q, out_bit_d;
    logic out_is_b_q, out_is_b_d;
    logic done_q, done_d;
    logic out_free;
    logic take_key;
    logic take_pay;
    logic emit;
    logic key_last;

    // ============================================================
    // next-state logic
    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        kidx_d = kidx_q;
        bidx_d = bidx_q;
        lead_d = lead_q;
        bcnt_d = bcnt_q;
        segmax_d = segmax_q;
        out_valid_d = out_valid_q;
        out_bit_d = out_bit_q;
        out_is_b_d = out_is_b_q;
        done_d = 1'b0;
        take_key = 1'b0;
        take_pay = 1'b0;
        emit = 1'b0;
        // output slot free when empty or being drained this cycle
        out_free = !out_valid_q || out_ready;
        key_last = (kidx_q == segmax_q - CNT_W'(1));
        if (out_ready)
            out_valid_d = 1'b0;
        unique case (state_q)
            ks_pkg::ST_IDLE:
            begin
                if (start_valid)
                begin
                    cfg_d = start_cfg;
                    // A-field part ignores the B format entirely
                    lead_d = lead_of(start_cfg.cfg);
                    bcnt_d = bcount_of(start_cfg);
                    // segment length does not depend on B format
                    segmax_d = lead_of(start_cfg.cfg)
                        + unprot_of(start_cfg);
                    kidx_d = '0;
                    bidx_d = '0;
                    state_d = ks_pkg::ST_A;
                end
            end
            ks_pkg::ST_A:
            begin
                if (cfg_q.a_ciphered)
                begin
                    take_key = key_valid && pay_valid && out_free;
                    take_pay = take_key;
                    emit = take_key;
                end
                else
                begin
                    // discarded bits need no payload and no output slot
                    take_key = key_valid;
                end
                if (take_key)
                begin
                    kidx_d = kidx_q + CNT_W'(1);
                    if (kidx_q == lead_q - CNT_W'(1))
                        state_d = ks_pkg::ST_B;
                end
            end
            ks_pkg::ST_B:
            begin
                // key bit kidx = lead + i meets B bit i
                take_key = key_valid && pay_valid && out_free;
                take_pay = take_key;
                emit = take_key;
                if (take_key)
                begin
                    kidx_d = kidx_q + CNT_W'(1);
                    bidx_d = bidx_q + CNT_W'(1);
                    if (bidx_q == bcnt_q - CNT_W'(1))
                    begin
                        if (key_last)
                        begin
                            done_d = 1'b1;
                            state_d = ks_pkg::ST_IDLE;
                        end
                        else
                        begin
                            state_d = ks_pkg::ST_TAIL;
                        end
                    end
                end
            end
            ks_pkg::ST_TAIL:
            begin
                // surplus bits drained so the next segment starts aligned
                take_key = key_valid;
                if (take_key)
                begin
                    kidx_d = kidx_q + CNT_W'(1);
                    if (key_last)
                    begin
                        done_d = 1'b1;
                        state_d = ks_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        if (emit)
        begin
            out_valid_d = 1'b1;
            out_bit_d = pay_bit ^ key_bit;
            out_is_b_d = (state_q == ks_pkg::ST_B);
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ks_pkg::ST_IDLE;
            cfg_q <= '0;
            kidx_q <= '0;
            bidx_q <= '0;
            lead_q <= '0;
            bcnt_q <= '0;
            segmax_q <= '0;
            out_valid_q <= 1'b0;
            out_bit_q <= 1'b0;
            out_is_b_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            kidx_q <= kidx_d;
            bidx_q <= bidx_d;
            lead_q <= lead_d;
            bcnt_q <= bcnt_d;
            segmax_q <= segmax_d;
            out_valid_q <= out_valid_d;
            out_bit_q <= out_bit_d;
            out_is_b_q <= out_is_b_d;
            done_q <= done_d;
        end
    end

    // ============================================================
    // outputs
    assign start_ready = (state_q == ks_pkg::ST_IDLE);
    assign key_ready = take_key;
    assign pay_ready = take_pay;
    assign out_valid = out_valid_q;
    assign out_bit = out_bit_q;
    assign out_is_b = out_is_b_q;
    assign seg_done = done_q;

endmodule : keystream_bfield_xor_mapper

`default_nettype wire

// ---- test/ks_far_model.sv ----
// far-side key stream source and payload source
`timescale 1ns/1ps
`default_nettype none
module ks_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic key_ready,
    input wire logic pay_ready,
    input wire logic seg_done,
    output logic key_valid,
    output logic key_bit,
    output logic pay_valid,
    output logic pay_bit
);
    // ========================================
    // bit indices restart with each segment
    logic [12:0] k_q;
    logic [12:0] p_q;
    logic [1:0] ph_q;
    logic kf;
    logic pf;
    always_ff @(posedge clk)
    begin
        ph_q <= rst ? 2'h0 : ph_q + 2'h1;
        k_q <= (rst || seg_done) ? '0 : k_q + 13'(key_ready);
        p_q <= (rst || seg_done) ? '0 : p_q + 13'(pay_ready);
    end
    assign kf = k_q[0] ^ k_q[2] ^ k_q[5];
    assign pf = p_q[1] ^ p_q[3] ^ p_q[4];
    // slow mode: the two sources gap on different phases
    assign key_valid = !slow || (ph_q != 2'h0);
    assign pay_valid = !slow || (ph_q != 2'h1);
    // a line not offered shows the inverse, never a stale bit
    assign key_bit = key_valid ? kf : !kf;
    assign pay_bit = pay_valid ? pf : !pf;
endmodule : ks_far_model
`default_nettype wire

// ---- test/ks_map_properties.sv ----
// port assertions for the key stream mapper
`timescale 1ns/1ps
`default_nettype none
module ks_map_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic start_valid,
    input wire logic start_ready,
    input wire logic key_valid,
    input wire logic key_bit,
    input wire logic key_ready,
    input wire logic pay_valid,
    input wire logic pay_bit,
    input wire logic pay_ready,
    input wire logic out_valid,
    input wire logic out_bit,
    input wire logic out_ready,
    input wire logic seg_done
);
    // ========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    start_busy_a: assert property (start_valid && start_ready |=>
        !start_ready) else $error("start_ready high after start");
    reset_idle_a: assert property ($fell(rst) |->
        start_ready && !out_valid && !seg_done) else $error("not idle");
    out_hold_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_bit)) else $error("output dropped");
    key_take_a: assert property (key_ready |-> key_valid)
        else $error("key taken without valid");
    pay_pair_a: assert property (pay_ready |->
        key_ready && pay_valid) else $error("payload taken alone");
    xor_map_a: assert property (key_ready && pay_ready |=>
        out_valid && out_bit == ($past(key_bit) ^ $past(pay_bit)))
        else $error("output bit not key xor payload");
    drop_quiet_a: assert property (key_ready && !pay_ready &&
        (!out_valid || out_ready) |=> !out_valid)
        else $error("dropped key bit reached output");
    done_pulse_a: assert property (seg_done |=> !seg_done)
        else $error("seg_done longer than one cycle");
    done_ready_a: assert property (seg_done |-> start_ready)
        else $error("not ready at seg_done");
    idle_quiet_a: assert property (start_ready |->
        !key_ready && !pay_ready) else $error("bits taken while idle");
endmodule : ks_map_checker
bind keystream_bfield_xor_mapper ks_map_checker ks_map_checker_inst (
    .clk, .rst, .start_valid, .start_ready, .key_valid, .key_bit,
    .key_ready, .pay_valid, .pay_bit, .pay_ready, .out_valid, .out_bit,
    .out_ready, .seg_done);
`default_nettype wire

// ---- test/keystream_bfield_xor_mapper_tb_top.sv ----
// self-checking bench for the key stream mapper
`timescale 1ns/1ps
`default_nettype none
module keystream_bfield_xor_mapper_tb_top;
    logic clk, rst, start_valid, start_ready, key_valid, key_bit;
    logic key_ready, pay_valid, pay_bit, pay_ready, out_valid;
    logic out_bit, out_is_b, out_ready, seg_done, slow, stall;
    ks_pkg::burst_cfg_t start_cfg;
    int bad_count = 0;
    int checks_done = 0;
    int key_taken = 0;
    keystream_bfield_xor_mapper keystream_bfield_xor_mapper_inst (
        .clk, .rst, .start_valid, .start_ready, .start_cfg, .key_valid,
        .key_bit, .key_ready, .pay_valid, .pay_bit, .pay_ready,
        .out_valid, .out_bit, .out_is_b, .out_ready, .seg_done);
    ks_far_model ks_far_model_inst (.clk, .rst, .slow, .key_ready,
        .pay_ready, .seg_done, .key_valid, .key_bit, .pay_valid, .pay_bit);
    // every key bit pulled, so a short or long tail shows up
    always @(posedge clk)
    begin
        if (key_ready === 1'h1 && key_valid === 1'h1)
            key_taken <= key_taken + 1;
    end
    // ========================================
    // helpers
    function automatic logic kf(input int k);
        return k[0] ^ k[2] ^ k[5];
    endfunction : kf
    function automatic logic pf(input int j);
        return j[1] ^ j[3] ^ j[4];
    endfunction : pf
    task automatic chk(input string s, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s exp %0h got %0h", s, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // one segment; expected bits rebuilt from the source patterns
    task automatic run_seg(input logic [6:0] c, input logic ci,
        input int lead, input int cnt, input int seg, input logic sk,
        input logic so);
        int na;
        int nb;
        int n;
        int la;
        int k0;
        logic e;
        logic done;
        na = 0;
        nb = 0;
        la = ci ? lead : 0;
        k0 = key_taken;
        done = 1'h0;
        slow = sk;
        stall = so;
        @(negedge clk);
        chk("start_ready", 16'h1, 16'(start_ready));
        start_cfg = ks_pkg::burst_cfg_t'({c, ci});
        start_valid = 1'h1;
        @(negedge clk);
        start_valid = 1'h0;
        for (n = 0; n < 20000 && !(done && !out_valid); n++)
        begin
            out_ready = !stall || n[1];
            if (out_valid === 1'h1 && out_ready)
            begin
                chk("out_is_b", 16'(na >= la), 16'(out_is_b));
                e = out_is_b ? kf(lead + nb) ^ pf(na + nb) : kf(na) ^ pf(na);
                chk("out_bit", 16'(e), 16'(out_bit));
                if (out_is_b)
                    nb++;
                else
                    na++;
            end
            done = done || seg_done;
            @(negedge clk);
        end
        if (n == 20000)
        begin
            bad_count++;
            end_sim;
        end
        chk("a_count", 16'(la), 16'(na));
        chk("b_count", 16'(cnt), 16'(nb));
        chk("seg_len", 16'(seg), 16'(key_taken - k0));
    endtask : run_seg
    // ========================================
    // scenarios: cfg bits are slot, configuration, format
    task automatic sc_full_cipher;
        run_seg({2'h1, 3'h0, 2'h0}, 1'h1, 40, 320, 360,
            1'h0, 1'h0);
    endtask : sc_full_cipher
    task automatic sc_single_full;
        run_seg({2'h1, 3'h1, 2'h2}, 1'h0, 40, 304, 360,
            1'h0, 1'h1);
    endtask : sc_single_full
    task automatic sc_long_4b;
        run_seg({2'h2, 3'h5, 2'h1}, 1'h1, 120, 1920, 2040,
            1'h1, 1'h0);
    endtask : sc_long_4b
    task automatic sc_double_4a;
        run_seg({2'h0, 3'h4, 2'h2}, 1'h1, 80, 1568, 1680,
            1'h1, 1'h1);
    endtask : sc_double_4a
    task automatic sc_long_cfg5;
        run_seg({2'h3, 3'h6, 2'h2}, 1'h0, 40, 2556, 2728,
            1'h0, 1'h0);
    endtask : sc_long_cfg5
    task automatic sc_long_cfg6;
        run_seg({2'h3, 3'h7, 2'h0}, 1'h0, 40, 4032, 4072,
            1'h0, 1'h1);
    endtask : sc_long_cfg6
    task automatic sc_double_cfg2;
        run_seg({2'h0, 3'h2, 2'h1}, 1'h1, 40, 1600, 1640,
            1'h0, 1'h0);
    endtask : sc_double_cfg2
    task automatic sc_long_cfg3;
        run_seg({2'h2, 3'h3, 2'h2}, 1'h0, 40, 1888, 1960,
            1'h1, 1'h0);
    endtask : sc_long_cfg3
    initial
    begin
        clk = 1'h0;
        forever #50 clk = !clk;
    end
    initial
    begin
        rst = 1'h1;
        start_valid = 1'h0;
        start_cfg = '0;
        out_ready = 1'h0;
        slow = 1'h0;
        stall = 1'h0;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        sc_full_cipher;
        sc_single_full;
        sc_long_4b;
        sc_double_4a;
        sc_long_cfg5;
        sc_long_cfg6;
        sc_double_cfg2;
        sc_long_cfg3;
        end_sim;
    end
endmodule : keystream_bfield_xor_mapper_tb_top
`default_nettype wire
